// File: core/timer_channel_output_control.sv
// Purpose: One 16-bit timer channel: counting, compare, reinit and output flag modes.
// Assumes: All pin and co-channel inputs synchronous to aclk; single AXI4-Lite master.
// Notes: Registers answer one cycle after both address and data are held.
// Notes on behaviour
// - Output mode 000: output high while the counter actively counts.
// - Output mode 001: clear output flag on each compare.
// - Output mode 010: set output flag on each compare.
// - Output mode 011: toggle output flag on each compare.
// - Output mode 100: toggle on compares alternating first and second compare values.
// - Output mode 101: set on compare, clear on secondary input edge.
// - Output mode 110: set on compare, clear on counter rollover.
// - Output mode 111: gated clock on output while counter active.
// - Reinit enable 0: ignore co-channel reinitialization requests.
// - Reinit enable 1: co-channels may force this counter to reinitialize.
// - Length 0 rolls over freely; length 1 reinitializes at compare.
// - Direction 0 counts up against first compare; 1 counts down.
// - Counting down, compare happens at the second compare value.
// - Alternating mode with length set alternates first and second compare targets.
// - Every compare sets the compare flag in status.
//
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module timer_channel_output_control #(
  parameter int WIDTH = 16,
  parameter int OWN_INDEX = 0
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Timer group
  input wire logic [3:0] counter_pins,
  input wire logic [3:0] cochannel_outputs,
  input wire logic cochannel_reinit_req,
  // Channel outputs
  output logic timer_output_flag,
  output logic irq
);

  if (WIDTH != 16) $error("WIDTH must be 16");
  if (OWN_INDEX < 0 || OWN_INDEX > 3) $error("OWN_INDEX must be 0..3");

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [15:0] byte_merge(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] st);
    logic [15:0] r;
    r = old;
    if (st[0]) r[7:0] = wd[7:0];
    if (st[1]) r[15:8] = wd[15:8];
    return r;
  endfunction
  function automatic logic rise(input logic now, input logic prev);
    return now & ~prev;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  timer_channel_pkg::channel_control_t ctrl_q, ctrl_d;
  logic [15:0] first_compare_value_q, first_compare_value_d;
  logic [15:0] second_compare_value_q, second_compare_value_d;
  logic [15:0] load_q, load_d;
  logic [15:0] cnt_q, cnt_d;
  logic [timer_channel_pkg::STAT_WIDTH-1:0] status_q, status_d;
  logic [timer_channel_pkg::STAT_WIDTH-1:0] mask_q, mask_d;
  logic alt_q, alt_d;
  logic stopped_q, stopped_d;
  logic armed_q, armed_d;
  logic flag_q, flag_d;
  logic irq_q, irq_d;
  logic prim_prev_q, prim_prev_d;
  logic sec_prev_q, sec_prev_d;
  logic [timer_channel_pkg::PRESCALE_BITS-1:0] div_q, div_d;
  logic aw_got_q, aw_got_d;
  logic w_got_q, w_got_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;

  // ----------------------------------------
  // Source selection and count events
  // ----------------------------------------
  logic prim_level, prim_is_tick, prim_tick, sec_level, own_src, active;
  logic prim_edge, prim_any_edge, sec_edge, step, step_down;
  logic [2:0] pre_sel;
  logic [15:0] target;
  logic compare_hit, roll_hit, reinit_req;
  always_comb begin
    pre_sel = ctrl_q.primary_src[2:0];
    prim_is_tick = ctrl_q.primary_src[3];
    prim_level = ctrl_q.primary_src[2] ? cochannel_outputs[ctrl_q.primary_src[1:0]]
                                       : counter_pins[ctrl_q.primary_src[1:0]];
    // Divide by 2^n pulses when the low n divider bits are all ones
    prim_tick = (pre_sel == 3'h0) ? 1'b1
              : &(div_q | ~((7'h01 << pre_sel) - 7'h01));
    sec_level = counter_pins[ctrl_q.secondary_src];
    own_src = !prim_is_tick && ctrl_q.primary_src[2] && (ctrl_q.primary_src[1:0] == 2'(OWN_INDEX));
    active = (ctrl_q.count_mode != timer_channel_pkg::CM_NOP) && !own_src && !stopped_q;
    prim_edge = prim_is_tick ? prim_tick : rise(prim_level, prim_prev_q);
    prim_any_edge = prim_is_tick ? prim_tick : (prim_level ^ prim_prev_q);
    sec_edge = rise(sec_level, sec_prev_q);
    step_down = ctrl_q.dir;
    case (ctrl_q.count_mode)
      timer_channel_pkg::CM_RISE: step = prim_edge;
      timer_channel_pkg::CM_BOTH: step = prim_any_edge;
      timer_channel_pkg::CM_GATED: step = prim_edge && sec_level;
      timer_channel_pkg::CM_QUAD: begin
        step = prim_any_edge;
        step_down = prim_level ~^ sec_level;
      end
      timer_channel_pkg::CM_DIR_SEC: begin
        step = prim_edge;
        step_down = sec_level;
      end
      timer_channel_pkg::CM_TRIGGERED: step = prim_edge && armed_q;
      timer_channel_pkg::CM_CASCADE: step = prim_edge;
      default: step = 1'b0;
    endcase
    step = step && active;
    // Alternating mode chooses its target by phase, else by direction
    if (ctrl_q.out_mode == timer_channel_pkg::OUT_TOGGLE_ALT) begin
      target = alt_q ? second_compare_value_q : first_compare_value_q;
    end else begin
      target = step_down ? second_compare_value_q : first_compare_value_q;
    end
    compare_hit = step && (cnt_q == target);
    roll_hit = step && (step_down ? (cnt_q == timer_channel_pkg::CNT_MIN)
                                  : (cnt_q == timer_channel_pkg::CNT_MAX));
    reinit_req = cochannel_reinit_req && ctrl_q.cochannel_reinit_enable;
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic aw_hs, w_hs, ar_hs, do_write, status_read;
  logic [timer_channel_pkg::STAT_WIDTH-1:0] events;
  always_comb begin
    aw_hs = s_axi_awvalid && s_axi_awready;
    w_hs = s_axi_wvalid && s_axi_wready;
    ar_hs = s_axi_arvalid && s_axi_arready;
    do_write = aw_got_q && w_got_q && !bvalid_q;
    status_read = ar_hs && (s_axi_araddr == timer_channel_pkg::OFS_STATUS);
    ctrl_d = ctrl_q;
    first_compare_value_d = first_compare_value_q;
    second_compare_value_d = second_compare_value_q;
    load_d = load_q;
    cnt_d = cnt_q;
    mask_d = mask_q;
    alt_d = alt_q;
    stopped_d = stopped_q;
    armed_d = armed_q;
    flag_d = flag_q;
    prim_prev_d = prim_level;
    sec_prev_d = sec_level;
    div_d = div_q + 7'h01;
    // Counter core
    if (reinit_req) begin
      cnt_d = load_q;
    end else if (compare_hit && ctrl_q.length) begin
      cnt_d = load_q;
    end else if (step) begin
      cnt_d = step_down ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
    end
    if (compare_hit) begin
      alt_d = !alt_q;
      armed_d = 1'b0;
      if (ctrl_q.single_shot) stopped_d = 1'b1;
    end
    if (ctrl_q.count_mode == timer_channel_pkg::CM_TRIGGERED && sec_edge) armed_d = 1'b1;
    // Output flag
    case (ctrl_q.out_mode)
      timer_channel_pkg::OUT_ACTIVE: flag_d = active;
      timer_channel_pkg::OUT_CLEAR: if (compare_hit) flag_d = 1'b0;
      timer_channel_pkg::OUT_SET: if (compare_hit) flag_d = 1'b1;
      timer_channel_pkg::OUT_TOGGLE: if (compare_hit) flag_d = !flag_q;
      timer_channel_pkg::OUT_TOGGLE_ALT: if (compare_hit) flag_d = !flag_q;
      // Set beats a clearing edge landing in the same cycle
      timer_channel_pkg::OUT_SET_SEC_CLR: begin
        if (compare_hit) flag_d = 1'b1;
        else if (sec_edge) flag_d = 1'b0;
      end
      timer_channel_pkg::OUT_SET_ROLL_CLR: begin
        if (compare_hit) flag_d = 1'b1;
        else if (roll_hit) flag_d = 1'b0;
      end
      // Registered copy of the source; relies on a counter output as source
      timer_channel_pkg::OUT_GATED_CLK: flag_d = active && prim_level;
      default: flag_d = 1'b0;
    endcase
    // Sticky events; a new event wins over the read that clears
    events = '0;
    events[timer_channel_pkg::STAT_COMPARE] = compare_hit;
    events[timer_channel_pkg::STAT_ROLLOVER] = roll_hit;
    status_d = (status_read ? '0 : status_q) | events;
    irq_d = |(status_d & mask_d);
    // Write channel
    aw_got_d = aw_got_q;
    w_got_d = w_got_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (aw_hs) begin
      aw_got_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (w_hs) begin
      w_got_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (do_write) begin
      aw_got_d = 1'b0;
      w_got_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = timer_channel_pkg::RESP_OKAY;
      case (awaddr_q)
        timer_channel_pkg::OFS_FIRST_CMP: first_compare_value_d = byte_merge(first_compare_value_q, wdata_q, wstrb_q);
        timer_channel_pkg::OFS_SECOND_CMP: second_compare_value_d = byte_merge(second_compare_value_q, wdata_q, wstrb_q);
        timer_channel_pkg::OFS_LOAD: load_d = byte_merge(load_q, wdata_q, wstrb_q);
        timer_channel_pkg::OFS_COUNTER: cnt_d = byte_merge(cnt_q, wdata_q, wstrb_q);
        timer_channel_pkg::OFS_CONTROL: begin
          ctrl_d = timer_channel_pkg::channel_control_t'(byte_merge(ctrl_q, wdata_q, wstrb_q));
          // A fresh configuration restarts a stopped one-shot and the alternation
          stopped_d = 1'b0;
          alt_d = 1'b0;
        end
        timer_channel_pkg::OFS_MASK: if (wstrb_q[0]) mask_d = wdata_q[timer_channel_pkg::STAT_WIDTH-1:0];
        timer_channel_pkg::OFS_STATUS: ;
        default: bresp_d = timer_channel_pkg::RESP_SLVERR;
      endcase
    end
    if (bvalid_q && s_axi_bready) bvalid_d = 1'b0;
    // Read channel
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (ar_hs) begin
      rvalid_d = 1'b1;
      rresp_d = timer_channel_pkg::RESP_OKAY;
      case (s_axi_araddr)
        timer_channel_pkg::OFS_FIRST_CMP: rdata_d = {16'h0000, first_compare_value_q};
        timer_channel_pkg::OFS_SECOND_CMP: rdata_d = {16'h0000, second_compare_value_q};
        timer_channel_pkg::OFS_LOAD: rdata_d = {16'h0000, load_q};
        timer_channel_pkg::OFS_COUNTER: rdata_d = {16'h0000, cnt_q};
        timer_channel_pkg::OFS_CONTROL: rdata_d = {16'h0000, ctrl_q};
        timer_channel_pkg::OFS_STATUS: rdata_d = {30'h00000000, status_q};
        timer_channel_pkg::OFS_MASK: rdata_d = {30'h00000000, mask_q};
        default: begin
          rdata_d = 32'h00000000;
          rresp_d = timer_channel_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= timer_channel_pkg::channel_control_t'(timer_channel_pkg::CTRL_RESET);
      first_compare_value_q <= 16'h0000;
      second_compare_value_q <= 16'h0000;
      load_q <= 16'h0000;
      cnt_q <= 16'h0000;
      status_q <= '0;
      mask_q <= '0;
      alt_q <= 1'b0;
      stopped_q <= 1'b0;
      armed_q <= 1'b0;
      flag_q <= 1'b0;
      irq_q <= 1'b0;
      prim_prev_q <= 1'b0;
      sec_prev_q <= 1'b0;
      div_q <= '0;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= 2'h0;
    end else begin
      ctrl_q <= ctrl_d;
      first_compare_value_q <= first_compare_value_d;
      second_compare_value_q <= second_compare_value_d;
      load_q <= load_d;
      cnt_q <= cnt_d;
      status_q <= status_d;
      mask_q <= mask_d;
      alt_q <= alt_d;
      stopped_q <= stopped_d;
      armed_q <= armed_d;
      flag_q <= flag_d;
      irq_q <= irq_d;
      prim_prev_q <= prim_prev_d;
      sec_prev_q <= sec_prev_d;
      div_q <= div_d;
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // Handshake readies are flops too; they drop while an item is held
  logic awready_q, wready_q, arready_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      arready_q <= 1'b0;
    end else begin
      awready_q <= !aw_got_d && !bvalid_d && !(aw_hs);
      wready_q <= !w_got_d && !bvalid_d && !(w_hs);
      arready_q <= !rvalid_d && !ar_hs;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign timer_output_flag = flag_q;
  assign irq = irq_q;

endmodule

// File: core/timer_channel_pkg.sv
// Purpose: Shared constants and types for one timer channel with AXI4-Lite access.
// Assumes: 32-bit AXI4-Lite data, one aligned word per register.
// Notes: Register offsets are byte addresses.
package timer_channel_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] OFS_FIRST_CMP = 8'h00;
  localparam logic [7:0] OFS_SECOND_CMP = 8'h04;
  localparam logic [7:0] OFS_LOAD = 8'h08;
  localparam logic [7:0] OFS_COUNTER = 8'h0C;
  localparam logic [7:0] OFS_CONTROL = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_MASK = 8'h18;

  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_MIN = 16'h0000;

  // Status and mask bit positions
  localparam int STAT_COMPARE = 0;
  localparam int STAT_ROLLOVER = 1;
  localparam int STAT_WIDTH = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Prescaler select top bit and divider width
  localparam int PRESCALE_BITS = 7;

  // ----------------------------------------
  // Field encodings
  // ----------------------------------------
  typedef enum logic [2:0] {
    OUT_ACTIVE = 3'b000,
    OUT_CLEAR = 3'b001,
    OUT_SET = 3'b010,
    OUT_TOGGLE = 3'b011,
    OUT_TOGGLE_ALT = 3'b100,
    OUT_SET_SEC_CLR = 3'b101,
    OUT_SET_ROLL_CLR = 3'b110,
    OUT_GATED_CLK = 3'b111
  } out_mode_t;

  typedef enum logic [2:0] {
    CM_NOP = 3'b000,
    CM_RISE = 3'b001,
    CM_BOTH = 3'b010,
    CM_GATED = 3'b011,
    CM_QUAD = 3'b100,
    CM_DIR_SEC = 3'b101,
    CM_TRIGGERED = 3'b110,
    CM_CASCADE = 3'b111
  } count_mode_t;

  typedef struct packed {
    logic [2:0] count_mode;
    logic [3:0] primary_src;
    logic [1:0] secondary_src;
    logic single_shot;
    logic length;
    logic dir;
    logic cochannel_reinit_enable;
    logic [2:0] out_mode;
  } channel_control_t;

endpackage

// File: test/timer_group_model.sv
// Purpose: Input pins and co-channel counters around one channel.
// Assumes: Commands change right after aclk edges.
// Notes: Only co-channel 1 runs; it toggles every cycle.
`timescale 1ns/1ps
module timer_group_model (
  // Clock
  input wire logic aclk,
  // Bench commands
  input wire logic run,
  input wire logic pin_pulse,
  input wire logic reinit_cmd,
  input wire logic own_flag,
  // Group side
  output logic [3:0] counter_pins,
  output logic [3:0] cochannel_outputs,
  output logic cochannel_reinit_req
);
  logic tog_q;
  // Stops low so the gated output has no stray edge
  always_ff @(posedge aclk) tog_q <= run ? ~tog_q : 1'b0;
  // Own output goes back on index 0 as in a real group
  assign cochannel_outputs = {2'b00, tog_q, own_flag};
  assign counter_pins = {3'b000, pin_pulse};
  assign cochannel_reinit_req = reinit_cmd;
endmodule

// File: test/timer_channel_output_control_chk.sv
// Purpose: Port checks for the timer channel.
// Assumes: Writes offer address and data together, full strobes.
// Notes: Control is shadowed from bus writes and trusted after settling.
`timescale 1ns/1ps
module timer_channel_output_control_chk #(
  parameter int OWN_INDEX = 0
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Channel
  input wire logic [3:0] cochannel_outputs,
  input wire logic timer_output_flag,
  input wire logic irq
);
  logic [15:0] ctl_q, ctl_d, msk_q, msk_d;
  logic [1:0] age_q, age_d;
  logic ok;
  // Any write restarts settling, the shadow leads the design by one edge
  always_comb begin
    ctl_d = ctl_q;
    msk_d = msk_q;
    age_d = (age_q == 2'h3) ? age_q : age_q + 2'h1;
    if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) begin
      age_d = 2'h0;
      if (s_axi_awaddr == timer_channel_pkg::OFS_CONTROL) ctl_d = s_axi_wdata[15:0];
      if (s_axi_awaddr == timer_channel_pkg::OFS_MASK) msk_d = s_axi_wdata[15:0];
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_q <= 16'h0000;
      msk_q <= 16'h0000;
      age_q <= 2'h0;
    end else begin
      ctl_q <= ctl_d;
      msk_q <= msk_d;
      age_q <= age_d;
    end
  end
  assign ok = (age_q == 2'h3);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_reset_quiet;
    $rose(aresetn) |-> !timer_output_flag && !irq;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("output busy after reset");
  property p_idle;
    ok && ctl_q[15:13] == 3'b000 && ctl_q[2:0] == 3'b000 |-> !timer_output_flag;
  endproperty
  a_idle: assert property (p_idle) else $error("flag high while stopped");
  property p_active;
    ok && ctl_q[15:6] == 10'h0C0 && ctl_q[2:0] == 3'b000 |-> timer_output_flag;
  endproperty
  a_active: assert property (p_active) else $error("flag low while counting");
  property p_own_src;
    ok && ctl_q[12:9] == 4'(4 + OWN_INDEX) && ctl_q[2:0] == 3'b000 |-> !timer_output_flag;
  endproperty
  a_own_src: assert property (p_own_src) else $error("counting on own output");
  property p_clear_only;
    ok && ctl_q[2:0] == 3'b001 && !timer_output_flag |=> !timer_output_flag;
  endproperty
  a_clear_only: assert property (p_clear_only) else $error("flag set in clear mode");
  property p_set_only;
    ok && ctl_q[2:0] == 3'b010 && timer_output_flag |=> timer_output_flag;
  endproperty
  a_set_only: assert property (p_set_only) else $error("flag cleared in set mode");
  property p_gated;
    ok && ctl_q[15:9] == 7'h15 && ctl_q[2:0] == 3'b111 && $changed(cochannel_outputs[1])
      |-> ##[1:2] $changed(timer_output_flag);
  endproperty
  a_gated: assert property (p_gated) else $error("gated clock not passed");
  property p_irq_masked;
    ok && msk_q[1:0] == 2'b00 |-> !irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("irq while masked");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("read answer late");
endmodule
bind timer_channel_output_control timer_channel_output_control_chk #(.OWN_INDEX(OWN_INDEX)) chk_u (.*);

// File: test/timer_channel_output_control_tb.sv
// Purpose: Register-driven tests of the timer channel output modes.
// Assumes: One bus master, full write strobes.
// Notes: Prescaler source 1000 steps the counter every cycle.
`timescale 1ns/1ps
module timer_channel_output_control_tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb, counter_pins, cochannel_outputs;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic cochannel_reinit_req, timer_output_flag, irq, run, pin_pulse, reinit_cmd, pf;
  int fail_count, samples_checked, h, l, n;
  timer_channel_output_control dut_u (.*);
  timer_group_model grp_u (.aclk(aclk), .run(run), .pin_pulse(pin_pulse), .reinit_cmd(reinit_cmd),
    .own_flag(timer_output_flag), .counter_pins(counter_pins), .cochannel_outputs(cochannel_outputs),
    .cochannel_reinit_req(cochannel_reinit_req));
  // ------
  // Tasks
  // ------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("Compares %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic tick(inout int k);
    @(posedge aclk);
    k++;
    if (k > 700) begin
      fail_count++;
      $display("Error wait expected done seen timeout");
      complete_run();
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    k = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      tick(k);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  task automatic axr(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    int k;
    k = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      tick(k);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask
  task automatic prog(input logic [15:0] c);
    axw(timer_channel_pkg::OFS_CONTROL, {16'h0000, c}, timer_channel_pkg::RESP_OKAY);
  endtask
  // Counter written last so the run starts from a known value
  task automatic setup(input logic [15:0] c1, c2, ld, ct, cn);
    axw(timer_channel_pkg::OFS_FIRST_CMP, {16'h0000, c1}, timer_channel_pkg::RESP_OKAY);
    axw(timer_channel_pkg::OFS_SECOND_CMP, {16'h0000, c2}, timer_channel_pkg::RESP_OKAY);
    axw(timer_channel_pkg::OFS_LOAD, {16'h0000, ld}, timer_channel_pkg::RESP_OKAY);
    prog(ct);
    axw(timer_channel_pkg::OFS_COUNTER, {16'h0000, cn}, timer_channel_pkg::RESP_OKAY);
  endtask
  task automatic wflag(input logic v, output int c);
    int k;
    k = 0;
    while (timer_output_flag !== v) tick(k);
    c = k;
  endtask
  // Full high and low spans, skipping the partial one in progress
  task automatic measure(output int hi, output int lo);
    int t;
    wflag(1'b0, t);
    wflag(1'b1, t);
    wflag(1'b0, hi);
    wflag(1'b1, lo);
  endtask
  // ------
  // Sequence
  // ------
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {run, pin_pulse, reinit_cmd} = 3'h0;
    s_axi_wstrb = 4'hF;
    fail_count = 0;
    samples_checked = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axr(timer_channel_pkg::OFS_CONTROL, timer_channel_pkg::RESP_OKAY, rd);
    chk("control reset", 32'h0, rd);
    axr(8'h1C, timer_channel_pkg::RESP_SLVERR, rd);
    axw(8'h1C, 32'h0000FFFF, timer_channel_pkg::RESP_SLVERR);
    setup(16'h0003, 16'h0007, 16'h0000, 16'h3000, 16'h0000);
    wflag(1'b1, n);
    chk("active flag", 32'h1, 32'(n < 5));
    repeat (4) @(posedge aclk);
    prog(16'h2800);
    repeat (6) @(posedge aclk);
    chk("own source flag", 32'h0, {31'h0, timer_output_flag});
    setup(16'h0003, 16'h0007, 16'h0000, 16'h3022, 16'h0000);
    wflag(1'b1, n);
    chk("set wait", 32'h1, 32'(n < 10));
    prog(16'h3021);
    wflag(1'b0, n);
    chk("clear wait", 32'h1, 32'(n < 10));
    setup(16'hFFF8, 16'h0007, 16'h0000, 16'h3006, 16'hFFF0);
    wflag(1'b1, n);
    wflag(1'b0, h);
    chk("rollover span", 32'd7, 32'(h));
    axr(timer_channel_pkg::OFS_STATUS, timer_channel_pkg::RESP_OKAY, rd);
    chk("status", 32'h3, rd);
    setup(16'h0100, 16'h0007, 16'h0000, 16'h3025, 16'h0000);
    wflag(1'b1, n);
    pin_pulse <= 1'b1;
    @(posedge aclk);
    pin_pulse <= 1'b0;
    wflag(1'b0, n);
    chk("secondary clear", 32'h1, 32'(n < 5));
    setup(16'h0003, 16'h0007, 16'h0000, 16'h3023, 16'h0000);
    measure(h, l);
    chk("toggle high", 32'd4, 32'(h));
    chk("toggle low", 32'd4, 32'(l));
    setup(16'h0003, 16'h0007, 16'h0000, 16'h3024, 16'h0000);
    measure(h, l);
    chk("alternate sum", 32'd12, 32'(h + l));
    chk("alternate product", 32'd32, 32'(h * l));
    setup(16'h0003, 16'h0005, 16'h0008, 16'h3033, 16'h0008);
    measure(h, l);
    chk("down high", 32'd4, 32'(h));
    chk("down low", 32'd4, 32'(l));
    prog(16'h2A07);
    run <= 1'b1;
    repeat (4) @(posedge aclk);
    n = 0;
    pf = timer_output_flag;
    for (int i = 0; i < 20; i++) begin
      @(posedge aclk);
      if (timer_output_flag !== pf) n++;
      pf = timer_output_flag;
    end
    run <= 1'b0;
    chk("gated edges", 32'h1, 32'(n > 15));
    setup(16'h0007, 16'h0007, 16'h0055, 16'h3000, 16'h1000);
    reinit_cmd <= 1'b1;
    repeat (3) @(posedge aclk);
    axr(timer_channel_pkg::OFS_COUNTER, timer_channel_pkg::RESP_OKAY, rd);
    chk("reinit ignored", 32'h0, 32'(rd[15:0] == 16'h0055));
    prog(16'h3008);
    repeat (3) @(posedge aclk);
    axr(timer_channel_pkg::OFS_COUNTER, timer_channel_pkg::RESP_OKAY, rd);
    chk("reinit forced", 32'h55, rd);
    reinit_cmd <= 1'b0;
    axw(timer_channel_pkg::OFS_MASK, 32'h1, timer_channel_pkg::RESP_OKAY);
    setup(16'h0003, 16'h0007, 16'h0000, 16'h3023, 16'h0000);
    repeat (8) @(posedge aclk);
    chk("irq raised", 32'h1, {31'h0, irq});
    prog(16'h0000);
    axr(timer_channel_pkg::OFS_STATUS, timer_channel_pkg::RESP_OKAY, rd);
    chk("compare flag", 32'h1, {31'h0, rd[0]});
    repeat (3) @(posedge aclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    complete_run();
  end
endmodule
